// ===== logic/drive_status_output_select.v
`timescale 1ns/1ps
`default_nettype none
`include "status_out_consts.vh"

// How it works
// [RULE1] each of two programmable outputs picks any status function independently.
// [RULE2] alarm changeover output defaults to alarm, accepts any other function.
// [RULE3] code 00 gives active in run mode, inactive in stop mode.
// [RULE4] run output is normally open: active means contacts closed.
// [RULE5] run output asserted while output frequency exceeds start frequency.
// [RULE6] first arrival output asserted when output frequency reaches set frequency.
// [RULE7] further arrival variants use accel and decel thresholds, separate on/off.
// [RULE8] every arrival transition carries hysteresis against chatter.
// [RULE9] code 01 is set-frequency arrival, inactive when not at set frequency.
// [RULE10] hysteresis band width is a configurable constant.
module drive_status_output_select (
   input  wire                 core_clk,
   input  wire                 srst,
   input  wire                 run_mode,
   input  wire                 alarm_active,
   input  wire [`FREQ_W-1:0]   out_freq,
   input  wire [`FREQ_W-1:0]   set_frequency_parameter,
   input  wire [`FREQ_W-1:0]   start_frequency_parameter,
   input  wire [`FREQ_W-1:0]   accel_threshold,
   input  wire [`FREQ_W-1:0]   decel_threshold,
   input  wire                 cfg_load,
   input  wire [`FUNC_W-1:0]   sel_out1,
   input  wire [`FUNC_W-1:0]   sel_out2,
   input  wire [`FUNC_W-1:0]   sel_alarm,
   output reg                  relay1_close_r,
   output reg                  relay2_close_r,
   output reg                  alarm_relay_r,
   output reg                  set_frequency_reached,
   output reg  [`FUNC_W-1:0]   sel1_r,
   output reg  [`FUNC_W-1:0]   sel2_r,
   output reg  [`FUNC_W-1:0]   sela_r
);

   // ----------------------------------------
   // function selection
   // ----------------------------------------
   function func_pick;
      input [`FUNC_W-1:0] sel;
      input               f_run;
      input               f_set;
      input               f_t1;
      input               f_t2;
      input               f_t3;
      input               f_t4;
      input               f_alm;
      begin
         case (sel)
            `FUNC_RUN:       func_pick = f_run;
            `FUNC_SET_REACH: func_pick = f_set;
            `FUNC_THR_FIRST: func_pick = f_t1;
            `FUNC_THR_2:     func_pick = f_t2;
            `FUNC_THR_3:     func_pick = f_t3;
            `FUNC_THR_LAST:  func_pick = f_t4;
            `FUNC_ALARM:     func_pick = f_alm;
            // unknown codes keep the contact open
            default:         func_pick = 1'b0;
         endcase
      end
   endfunction

   // ----------------------------------------
   // status functions
   // ----------------------------------------
   wire                 acc_up;
   wire                 dec_up;
   wire                 set_up;
   wire                 set_hi;
   wire                 over_now;
   wire                 accel;
   wire                 decel;
   wire [`FREQ_W:0]     set_top;
   wire [3*`FUNC_W-1:0] sel_all;
   wire [2:0]           pick;
   reg                  run_sig_r;
   reg                  dir_up_r;
   reg                  set_over_r;
   reg                  t3_r;
   reg                  t4_r;
   reg                  alarm_q_r;
   reg  [`FREQ_W-1:0]   prev_freq_r;
   genvar               gi;

   assign accel   = out_freq > prev_freq_r;
   assign decel   = out_freq < prev_freq_r;
   assign set_top = {1'b0, set_frequency_parameter} + {1'b0, `HYST_BAND};

   // [RULE10] band set by one constant
   hyst_compare u_acc (
      .core_clk  (core_clk),
      .srst      (srst),
      .freq      (out_freq),
      .on_level  (accel_threshold),
      .off_level (accel_threshold),
      .above_r   (acc_up)
   );

   hyst_compare u_dec (
      .core_clk  (core_clk),
      .srst      (srst),
      .freq      (out_freq),
      .on_level  (decel_threshold),
      .off_level (decel_threshold),
      .above_r   (dec_up)
   );

   // [RULE6] reach set frequency
   hyst_compare u_set (
      .core_clk  (core_clk),
      .srst      (srst),
      .freq      (out_freq),
      .on_level  (set_frequency_parameter),
      .off_level (set_frequency_parameter),
      .above_r   (set_up)
   );

   // overshoot above set plus band counts as away
   assign set_hi = {1'b0, out_freq} > set_top;

   // ----------------------------------------
   // direction of travel
   // ----------------------------------------
   // the last non-zero step is kept, so a pause on a ramp keeps
   // its direction; reset assumes the first move is upwards
   always @(posedge core_clk) begin
      if (srst) begin
         prev_freq_r <= {`FREQ_W{1'b0}};
         dir_up_r    <= 1'b1;
      end else begin
         prev_freq_r <= out_freq;
         if (accel) begin
            dir_up_r <= 1'b1;
         end else if (decel) begin
            dir_up_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // run signal and alarm
   // ----------------------------------------
   always @(posedge core_clk) begin
      if (srst) begin
         run_sig_r <= 1'b0;
         alarm_q_r <= 1'b0;
      end else begin
         // [RULE3] run vs stop; [RULE5] above start frequency
         run_sig_r <= run_mode && (out_freq > start_frequency_parameter);
         alarm_q_r <= alarm_active;
      end
   end

   // ----------------------------------------
   // set-frequency arrival
   // ----------------------------------------
   // once past set plus band the output stays off until the frequency
   // is back at set, so the upper edge cannot chatter either
   // [RULE8] band on the upper edge
   assign over_now = set_hi || (set_over_r && (out_freq > set_frequency_parameter));

   always @(posedge core_clk) begin
      if (srst) begin
         set_over_r            <= 1'b0;
         set_frequency_reached <= 1'b0;
      end else begin
         set_over_r            <= over_now;
         // [RULE9] off when away from set
         set_frequency_reached <= run_mode && set_up && !over_now;
      end
   end

   // ----------------------------------------
   // threshold variants
   // ----------------------------------------
   // direction is registered with the comparators, so a single step
   // across a threshold is still seen one edge later
   always @(posedge core_clk) begin
      if (srst) begin
         t3_r <= 1'b0;
         t4_r <= 1'b0;
      end else begin
         // [RULE7] on at accel level rising, off at decel level falling
         if (dir_up_r && acc_up) begin
            t3_r <= 1'b1;
         end else if (!dir_up_r && !dec_up) begin
            t3_r <= 1'b0;
         end
         // [RULE7] between both thresholds, whichever is higher
         t4_r <= acc_up ^ dec_up;
      end
   end

   // ----------------------------------------
   // function pick per output
   // ----------------------------------------
   assign sel_all = {sela_r, sel2_r, sel1_r};

   // [RULE1] same decoder for each output
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_pick
         assign pick[gi] = func_pick(sel_all[gi*`FUNC_W +: `FUNC_W], run_sig_r,
                                     set_frequency_reached, acc_up, t3_r, t4_r,
                                     dec_up, alarm_q_r);
      end
   endgenerate

   // ----------------------------------------
   // selection registers and relays
   // ----------------------------------------
   always @(posedge core_clk) begin
      if (srst) begin
         sel1_r         <= `SEL1_RST;
         sel2_r         <= `SEL2_RST;
         // [RULE2] alarm by default
         sela_r         <= `SELA_RST;
         relay1_close_r <= 1'b0;
         relay2_close_r <= 1'b0;
         alarm_relay_r  <= 1'b0;
      end else begin
         if (cfg_load) begin
            // [RULE1] independent choice
            sel1_r <= sel_out1;
            sel2_r <= sel_out2;
            // [RULE2] any function allowed
            sela_r <= sel_alarm;
         end
         // [RULE4] active means contact closed
         relay1_close_r <= pick[0];
         relay2_close_r <= pick[1];
         alarm_relay_r  <= pick[2];
      end
   end

endmodule // drive_status_output_select
`default_nettype wire

// ===== inc/status_out_consts.vh
`ifndef STATUS_OUT_CONSTS_VH
`define STATUS_OUT_CONSTS_VH

// ----------------------------------------
// widths
// ----------------------------------------
`define FREQ_W          16
`define FUNC_W          4

// ----------------------------------------
// function codes
// ----------------------------------------
`define FUNC_RUN        4'h0
`define FUNC_SET_REACH  4'h1
`define FUNC_THR_FIRST  4'h2
`define FUNC_THR_2      4'h3
`define FUNC_THR_3      4'h4
`define FUNC_THR_LAST   4'h5
`define FUNC_ALARM      4'h6

// ----------------------------------------
// reset values of selections
// ----------------------------------------
`define SEL1_RST        4'h0
`define SEL2_RST        4'h1
`define SELA_RST        4'h6

// ----------------------------------------
// hysteresis band, in frequency units
// ----------------------------------------
`define HYST_BAND       16'h0004

`endif

// ===== logic/hyst_compare.v
`timescale 1ns/1ps
`default_nettype none
`include "status_out_consts.vh"

// level comparator with hysteresis: turns on at or above on_level,
// off below off_level minus the band
module hyst_compare (
   input  wire                 core_clk,
   input  wire                 srst,
   input  wire [`FREQ_W-1:0]   freq,
   input  wire [`FREQ_W-1:0]   on_level,
   input  wire [`FREQ_W-1:0]   off_level,
   output reg                  above_r
);

   wire [`FREQ_W:0] off_lim;
   assign off_lim = {1'b0, off_level};

   // ----------------------------------------
   // comparison
   // ----------------------------------------
   always @(posedge core_clk) begin
      if (srst) begin
         above_r <= 1'b0;
      end else if (!above_r) begin
         // [RULE8] turn-on edge
         above_r <= (freq >= on_level);
      end else begin
         // [RULE8] band on release
         above_r <= ({1'b0, freq} + {1'b0, `HYST_BAND} >= off_lim);
      end
   end

endmodule // hyst_compare
`default_nettype wire

// ===== sim/status_sel_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "status_out_consts.vh"
module status_sel_chk (
   input wire logic               core_clk,
   input wire logic               srst,
   input wire logic               run_mode,
   input wire logic               cfg_load,
   input wire logic [`FREQ_W-1:0] out_freq,
   input wire logic [`FREQ_W-1:0] set_frequency_parameter,
   input wire logic [`FREQ_W-1:0] start_frequency_parameter,
   input wire logic [`FUNC_W-1:0] sel_out1,
   input wire logic               relay1_close_r,
   input wire logic               relay2_close_r,
   input wire logic               set_frequency_reached,
   input wire logic [`FUNC_W-1:0] sel1_r,
   input wire logic [`FUNC_W-1:0] sel2_r,
   input wire logic [`FUNC_W-1:0] sela_r
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   // run qualifies one edge, relay follows on the next
   sequence run_on;
      run_mode && out_freq > start_frequency_parameter ##1 sel1_r == `FUNC_RUN;
   endsequence
   sequence run_off;
      !(run_mode && out_freq > start_frequency_parameter) ##1 sel1_r == `FUNC_RUN;
   endsequence
   chk_run_close: assert property (run_on |=> relay1_close_r)
      else $error("run relay open in run");
   chk_run_open: assert property (run_off |=> !relay1_close_r)
      else $error("run relay closed in stop");
   chk_reset_vals: assert property (disable iff (1'b0) srst |=> sel1_r == `SEL1_RST
      && sel2_r == `SEL2_RST && sela_r == `SELA_RST && !relay1_close_r)
      else $error("bad reset state");
   chk_cfg_latch: assert property (cfg_load |=> sel1_r == $past(sel_out1))
      else $error("selection not latched");
   chk_sel_hold: assert property (!cfg_load |=> $stable(sel1_r))
      else $error("selection moved");
   chk_bad_code: assert property (sel1_r > `FUNC_ALARM |=> !relay1_close_r)
      else $error("unknown code drives relay");
   chk_set_relay: assert property (sel2_r == `FUNC_SET_REACH
      |=> relay2_close_r == $past(set_frequency_reached))
      else $error("relay2 not following arrival");
   chk_set_gate: assert property (!run_mode |=> !set_frequency_reached)
      else $error("arrival while stopped");
   // one extra bit so a set value near full scale cannot wrap
   chk_set_band: assert property (set_frequency_reached |-> {1'b0, $past(out_freq)}
      <= {1'b0, $past(set_frequency_parameter)} + {1'b0, `HYST_BAND})
      else $error("arrival beyond band");
endmodule // status_sel_chk
bind drive_status_output_select status_sel_chk chk (.core_clk, .srst, .run_mode, .cfg_load,
   .out_freq, .set_frequency_parameter, .start_frequency_parameter, .sel_out1,
   .relay1_close_r, .relay2_close_r, .set_frequency_reached, .sel1_r, .sel2_r, .sela_r);
`default_nettype wire

// ===== sim/relay_contacts.sv
`timescale 1ns/1ps
`default_nettype none
module relay_contacts (
   input  wire logic       core_clk,
   input  wire logic [2:0] coil,
   output var  logic [2:0] contact_r
);
   // normally open, one cycle of pull-in
   always @(posedge core_clk) contact_r <= coil;
endmodule // relay_contacts
`default_nettype wire

// ===== sim/drive_status_output_select_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "status_out_consts.vh"
module drive_status_output_select_tb_top;
   logic               core_clk = 0, srst = 1, run_mode = 0, alarm_active = 0, cfg_load = 0;
   logic [`FREQ_W-1:0] out_freq = 0, set_f = 0, start_f = 0, acc = 0, dec = 0;
   logic [`FUNC_W-1:0] s1 = 0, s2 = 1, sa = 6, sel1_r, sel2_r, sela_r;
   logic               r1, r2, ra, sfr, obs = 0;
   logic [2:0]         contact_r;
   logic [7:0]         e, q[$];
   logic [23:0]        tbl[10] = '{24'h201001, 24'h200fd1, 24'h200fb0, 24'h301001, 24'h3007e1,
                                   24'h300700, 24'h500901, 24'h400c01, 24'h300fb0, 24'h301001};
   integer             fails = 0, checked = 0, seed = 32'h77b8b6e5, i;
   always #20 core_clk = ~core_clk;
   drive_status_output_select dut (.core_clk(core_clk), .srst(srst), .run_mode(run_mode),
      .alarm_active(alarm_active), .out_freq(out_freq), .set_frequency_parameter(set_f),
      .start_frequency_parameter(start_f), .accel_threshold(acc), .decel_threshold(dec),
      .cfg_load(cfg_load), .sel_out1(s1), .sel_out2(s2), .sel_alarm(sa),
      .relay1_close_r(r1), .relay2_close_r(r2), .alarm_relay_r(ra),
      .set_frequency_reached(sfr), .sel1_r(sel1_r), .sel2_r(sel2_r), .sela_r(sela_r));
   relay_contacts load (.core_clk(core_clk), .coil({r1, r2, ra}), .contact_r(contact_r));
   task step(input integer n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task cmp(input string nm, input [11:0] seen, input [11:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // settle covers selection, relay and contact stages
   task expect_out(input [3:0] mask, input [3:0] val);
      step(4);
      q.push_back({mask, val});
      obs = 1;
      step(1);
      obs = 0;
   endtask
   task load_sel;
      cfg_load = 1;
      step(1);
      cfg_load = 0;
   endtask
   // falling edge: the rising edge would race the stage that launches them
   always @(negedge core_clk) if (obs) begin
      e = q.pop_front();
      cmp("contacts", {8'h00, e[7:4] & {contact_r, sfr}}, {8'h00, e[3:0]});
   end
   task report_and_stop;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      #100000;
      fails++;
      report_and_stop;
   end
   initial begin
      step(10);
      srst = 0;
      cmp("sel", {sel1_r, sel2_r, sela_r}, {`SEL1_RST, `SEL2_RST, `SELA_RST});
      set_f = 16'hffff;
      for (i = 0; i < 8; i++) begin
         out_freq = $random(seed) & 16'h7fff;
         start_f = $random(seed) & 16'h7fff;
         run_mode = $random(seed);
         expect_out(4'hb, {run_mode && out_freq > start_f, 3'b000});
      end
      $display("test run done");
      {run_mode, start_f, set_f, out_freq} = {1'b1, 16'h0, 16'h1000, 16'h1000};
      expect_out(4'hd, 4'hd);
      out_freq = 16'h1004;
      expect_out(4'hd, 4'hd);
      out_freq = 16'h1005;
      expect_out(4'hd, 4'h8);
      run_mode = 0;
      expect_out(4'hd, 4'h0);
      $display("test arrival done");
      {alarm_active, s1, s2, sa} = {1'b1, `FUNC_ALARM, `FUNC_RUN, `FUNC_RUN};
      load_sel;
      cmp("sel", {sel1_r, sel2_r, sela_r}, {`FUNC_ALARM, `FUNC_RUN, `FUNC_RUN});
      expect_out(4'he, 4'h8);
      run_mode = 1;
      expect_out(4'he, 4'he);
      s1 = 4'h7;
      load_sel;
      expect_out(4'he, 4'h6);
      $display("test select done");
      {acc, dec} = {16'h0100, 16'h0080};
      for (i = 0; i < 10; i++) begin
         s1 = tbl[i][23:20];
         alarm_active = $random(seed);
         out_freq = tbl[i][19:4];
         load_sel;
         expect_out(4'h8, {tbl[i][0], 3'b000});
      end
      $display("test threshold done");
      report_and_stop;
   end
endmodule // drive_status_output_select_tb_top
`default_nettype wire
